// File: hdl/ptwl_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types of the terminal and wiper latch control
// ----------------------------------------------------------------------------
package ptwl_pkg;

  // --------------------------------------------------------------------------
  // Memory map
  // --------------------------------------------------------------------------
  localparam int MEM_DEPTH = 16;
  localparam logic [3:0] ADDR_WIPER = 4'h0;
  localparam logic [3:0] ADDR_TERM_CTRL = 4'h4;

  // --------------------------------------------------------------------------
  // Reset values and full-scale limits
  // --------------------------------------------------------------------------
  localparam logic [7:0] WIPER_POR_8BIT = 8'h7F;
  localparam logic [7:0] WIPER_POR_7BIT = 8'h3F;
  localparam logic [7:0] WIPER_MAX_8BIT = 8'hFF;
  localparam logic [7:0] WIPER_MAX_7BIT = 8'h7F;
  localparam logic [3:0] TERM_CTRL_POR = 4'hF;
  localparam logic [3:0] TERM_CTRL_RSVD = 4'hF;
  localparam logic [3:0] TERM_POR = 4'hE;

  // --------------------------------------------------------------------------
  // Terminal control field positions
  // --------------------------------------------------------------------------
  localparam int TERM_CTRL_SOFT_N = 3;
  localparam int TERM_CTRL_A = 2;
  localparam int TERM_CTRL_W = 1;
  localparam int TERM_CTRL_B = 0;

  // --------------------------------------------------------------------------
  // Pin synchroniser lanes and their reset levels
  // --------------------------------------------------------------------------
  localparam int PIN_CS_N = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DISCONNECT_N = 2;
  localparam int PIN_LATCH_N = 3;
  localparam logic [3:0] SYNC_INIT = 4'hD;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam logic [3:0] STATIC_CYCLES = 4'h8;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_WRITE = 2'h0,
    CMD_INC = 2'h1,
    CMD_DEC = 2'h2,
    CMD_READ = 2'h3
  } ptwl_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_ERROR = 2'h3
  } ptwl_fsm_t;

  typedef struct packed {
    logic valid;
    ptwl_op_t op;
    logic [3:0] addr;
    logic [7:0] data;
  } ptwl_cmd_t;

  typedef struct packed {
    logic a_conn;
    logic w_conn;
    logic b_conn;
    logic wb_short;
  } ptwl_term_t;

  typedef struct packed {
    logic [3:0] f1;
    logic [3:0] f2;
    logic [3:0] f3;
    logic [3:0] out;
  } ptwl_sync_state_t;

  typedef struct packed {
    ptwl_fsm_t st;
    logic [7:0] wiper;
    logic [3:0] term_ctrl;
    logic [7:0] pos;
    ptwl_term_t term;
    logic [7:0] rd_data;
    logic rd_valid;
    logic err;
    logic stat;
    logic sclk_prev;
    logic [3:0] idle_cnt;
  } ptwl_state_t;

endpackage : ptwl_pkg

// File: hdl/ptwl_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------------------
module ptwl_sync
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Raw pins
  input wire logic [3:0] pins_i,
  // Filtered levels
  output logic [3:0] pins_o
);

  ptwl_pkg::ptwl_sync_state_t s_r;
  ptwl_pkg::ptwl_sync_state_t s_nxt;

  // Shift chain; first stage feeds only the second
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.f1 = pins_i;
    s_nxt.f2 = s_r.f1;
    s_nxt.f3 = s_r.f2;
    // Take a lane only once stages two and three agree
    for (int i = 0; i < 4; i++)
    begin
      if (s_r.f2[i] == s_r.f3[i])
      begin
        s_nxt.out[i] = s_r.f2[i];
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_r <= {4{ptwl_pkg::SYNC_INIT}};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pins_o = s_r.out;

endmodule : ptwl_sync
`default_nettype wire

// File: hdl/ptwl_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Pin low: open A, join wiper to B
// - Pin active overrides control bits, keeps them
// - Shutdown keeps wiper register; exit restores position
// - Control writes never touch wiper or interface
// - Four control bits: A, W, B, soft shutdown
// - Soft shutdown ignores connect bits, retains them
// - Latch high blocks register to wiper transfer
// - Latch low: wiper follows register continuously
// - Register updates regardless of latch; chip select gates
// - Latched value is always a whole register word
// - Static mode: select high, clock quiet
// - Sixteen eight-bit volatile locations
// - Only wiper and control implemented; rest reserved
// - Bad address or op: error, memory untouched
// - Error holds until select goes high
// - Reset wiper to mid-scale 7Fh or 3Fh
// - Reset control to all ones; upper nibble ones
// - Soft bit zero forces shutdown, one releases
// - Connect bit one connects, zero disconnects
module ptwl_top
#(
  parameter bit RES_7BIT = 1'b0
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Pins from outside the clock domain
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic terminal_disconnect_pin_n_i,
  input wire logic wiper_latch_n_i,
  // Decoded serial commands, same clock
  input wire ptwl_pkg::ptwl_cmd_t cmd_i,
  // Read answer and error
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic command_error_o,
  // Analog side
  output ptwl_pkg::ptwl_term_t term_o,
  output logic [7:0] wiper_pos_o,
  // Register views and current mode
  output logic [7:0] wiper_reg_o,
  output logic [7:0] terminal_control_zero_o,
  output logic static_mode_o
);

  // --------------------------------------------------------------------------
  // Variant constants
  // --------------------------------------------------------------------------
  localparam logic [7:0] WIPER_POR = RES_7BIT ? ptwl_pkg::WIPER_POR_7BIT : ptwl_pkg::WIPER_POR_8BIT;
  localparam logic [7:0] WIPER_MAX = RES_7BIT ? ptwl_pkg::WIPER_MAX_7BIT : ptwl_pkg::WIPER_MAX_8BIT;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Only two of the sixteen locations exist, each with its own op set
  function automatic logic cmd_legal(input logic [3:0] addr, input ptwl_pkg::ptwl_op_t op);
    logic ok;
    ok = 1'b0;
    if (addr == ptwl_pkg::ADDR_WIPER)
    begin
      ok = 1'b1;
    end
    else if (addr == ptwl_pkg::ADDR_TERM_CTRL)
    begin
      ok = (op == ptwl_pkg::CMD_WRITE) || (op == ptwl_pkg::CMD_READ);
    end
    return ok;
  endfunction : cmd_legal

  // Control register as read back, reserved nibble forced high
  function automatic logic [7:0] term_ctrl_word(input logic [3:0] bits);
    return {ptwl_pkg::TERM_CTRL_RSVD, bits};
  endfunction : term_ctrl_word

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  logic [3:0] pins_s;

  ptwl_sync u_sync
  (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .pins_i({wiper_latch_n_i, terminal_disconnect_pin_n_i, sclk_i, cs_n_i}),
    .pins_o(pins_s)
  );

  logic cs_n_s;
  logic sclk_s;
  logic disconnect_n_s;
  logic latch_n_s;

  // Named views of the filtered pins
  assign cs_n_s = pins_s[ptwl_pkg::PIN_CS_N];
  assign sclk_s = pins_s[ptwl_pkg::PIN_SCLK];
  assign disconnect_n_s = pins_s[ptwl_pkg::PIN_DISCONNECT_N];
  assign latch_n_s = pins_s[ptwl_pkg::PIN_LATCH_N];

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  ptwl_pkg::ptwl_state_t s_r;
  ptwl_pkg::ptwl_state_t s_nxt;
  logic shutdown;
  logic take;

  // Next-state logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    take = 1'b0;

    // Chip select session and error recovery
    case (s_r.st)
      ptwl_pkg::ST_IDLE:
      begin
        if (!cs_n_s)
        begin
          s_nxt.st = ptwl_pkg::ST_ACTIVE;
        end
      end
      ptwl_pkg::ST_ACTIVE:
      begin
        if (cs_n_s)
        begin
          s_nxt.st = ptwl_pkg::ST_IDLE;
        end
        else
        begin
          take = cmd_i.valid;
        end
      end
      ptwl_pkg::ST_ERROR:
      begin
        // Only a select high ends the error; the next low starts afresh
        if (cs_n_s)
        begin
          s_nxt.st = ptwl_pkg::ST_IDLE;
          s_nxt.err = 1'b0;
        end
      end
      default:
      begin
        s_nxt.st = ptwl_pkg::ST_IDLE;
      end
    endcase

    // Command execution, single cycle so the register never holds a half word
    if (take)
    begin
      if (!cmd_legal(cmd_i.addr, cmd_i.op))
      begin
        s_nxt.err = 1'b1;
        s_nxt.st = ptwl_pkg::ST_ERROR;
      end
      else if (cmd_i.addr == ptwl_pkg::ADDR_WIPER)
      begin
        case (cmd_i.op)
          ptwl_pkg::CMD_WRITE:
          begin
            s_nxt.wiper = cmd_i.data & WIPER_MAX;
          end
          ptwl_pkg::CMD_INC:
          begin
            if (s_r.wiper < WIPER_MAX)
            begin
              s_nxt.wiper = s_r.wiper + 8'h01;
            end
          end
          ptwl_pkg::CMD_DEC:
          begin
            if (s_r.wiper != 8'h00)
            begin
              s_nxt.wiper = s_r.wiper - 8'h01;
            end
          end
          default:
          begin
            s_nxt.rd_data = s_r.wiper;
            s_nxt.rd_valid = 1'b1;
          end
        endcase
      end
      else
      begin
        // Control writes touch only the low nibble, never the wiper
        if (cmd_i.op == ptwl_pkg::CMD_WRITE)
        begin
          s_nxt.term_ctrl = cmd_i.data[3:0];
        end
        else
        begin
          s_nxt.rd_data = term_ctrl_word(s_r.term_ctrl);
          s_nxt.rd_valid = 1'b1;
        end
      end
    end

    // Latch gating of the analog wiper; register keeps updating meanwhile
    if (!latch_n_s)
    begin
      s_nxt.pos = s_r.wiper;
    end

    // Terminal switches: either shutdown source wins, bits left intact
    shutdown = !disconnect_n_s || !s_r.term_ctrl[ptwl_pkg::TERM_CTRL_SOFT_N];
    if (shutdown)
    begin
      s_nxt.term.a_conn = 1'b0;
      s_nxt.term.w_conn = 1'b0;
      s_nxt.term.b_conn = 1'b0;
      s_nxt.term.wb_short = 1'b1;
    end
    else
    begin
      s_nxt.term.a_conn = s_r.term_ctrl[ptwl_pkg::TERM_CTRL_A];
      s_nxt.term.w_conn = s_r.term_ctrl[ptwl_pkg::TERM_CTRL_W];
      s_nxt.term.b_conn = s_r.term_ctrl[ptwl_pkg::TERM_CTRL_B];
      s_nxt.term.wb_short = 1'b0;
    end

    // Static mode: select high and no clock edge for a short window
    s_nxt.sclk_prev = sclk_s;
    if (!cs_n_s || (sclk_s != s_r.sclk_prev))
    begin
      s_nxt.idle_cnt = 4'h0;
    end
    else if (s_r.idle_cnt != ptwl_pkg::STATIC_CYCLES)
    begin
      s_nxt.idle_cnt = s_r.idle_cnt + 4'h1;
    end
    s_nxt.stat = cs_n_s && (s_nxt.idle_cnt == ptwl_pkg::STATIC_CYCLES);
  end

  // State register; reset stands for power-on and brown-out
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_r.st <= ptwl_pkg::ST_IDLE;
      s_r.wiper <= WIPER_POR;
      s_r.term_ctrl <= ptwl_pkg::TERM_CTRL_POR;
      s_r.pos <= WIPER_POR;
      s_r.term <= ptwl_pkg::TERM_POR; // All connected, no short
      s_r.rd_data <= 8'h00;
      s_r.rd_valid <= 1'b0;
      s_r.err <= 1'b0;
      s_r.stat <= 1'b0;
      s_r.sclk_prev <= 1'b0;
      s_r.idle_cnt <= 4'h0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from the state register
  // --------------------------------------------------------------------------
  assign rd_data_o = s_r.rd_data;
  assign rd_valid_o = s_r.rd_valid;
  assign command_error_o = s_r.err;
  assign term_o = s_r.term;
  assign wiper_pos_o = s_r.pos;
  assign wiper_reg_o = s_r.wiper;
  assign terminal_control_zero_o = {ptwl_pkg::TERM_CTRL_RSVD, s_r.term_ctrl};
  assign static_mode_o = s_r.stat;

endmodule : ptwl_top
`default_nettype wire

// File: test/ptwl_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker of terminal and latch control
// ----------------------------------------
module ptwl_top_props
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Pins and commands
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic terminal_disconnect_pin_n_i,
  input wire logic wiper_latch_n_i,
  input wire ptwl_pkg::ptwl_cmd_t cmd_i,
  // Device outputs
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic command_error_o,
  input wire ptwl_pkg::ptwl_term_t term_o,
  input wire logic [7:0] wiper_pos_o,
  input wire logic [7:0] wiper_reg_o,
  input wire logic [7:0] terminal_control_zero_o,
  input wire logic static_mode_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Illegal command seen on the port
  logic bad;
  assign bad = cmd_i.valid && ((cmd_i.addr != ptwl_pkg::ADDR_WIPER && cmd_i.addr != ptwl_pkg::ADDR_TERM_CTRL)
    || (cmd_i.addr == ptwl_pkg::ADDR_TERM_CTRL
    && (cmd_i.op == ptwl_pkg::CMD_INC || cmd_i.op == ptwl_pkg::CMD_DEC)));

  // Eight cycles cover the pin filter lag with margin
  sequence pin_low; !terminal_disconnect_pin_n_i [*8]; endsequence
  sequence latch_high; wiper_latch_n_i [*8]; endsequence
  sequence latch_low; !wiper_latch_n_i [*8]; endsequence
  sequence err_held; (command_error_o && !cs_n_i) [*6]; endsequence

  chk_pin_shutdown: assert property (pin_low |-> term_o.wb_short && !term_o.a_conn)
    else $error("pin low without shutdown shape");
  chk_conn_follow: assert property (!term_o.wb_short |->
    {term_o.a_conn, term_o.w_conn, term_o.b_conn} == $past(terminal_control_zero_o[2:0]))
    else $error("terminals differ from connect bits");
  chk_soft_force: assert property (!$past(terminal_control_zero_o[3]) |-> term_o.wb_short)
    else $error("soft shutdown not applied");
  chk_pin_release: assert property ((terminal_disconnect_pin_n_i && terminal_control_zero_o[3]) [*8]
    |-> !term_o.wb_short)
    else $error("shutdown kept without cause");
  chk_latch_hold: assert property (latch_high |=> $stable(wiper_pos_o))
    else $error("wiper moved while latch high");
  chk_latch_follow: assert property (latch_low |-> wiper_pos_o == $past(wiper_reg_o))
    else $error("wiper not following register");
  chk_read_data: assert property (rd_valid_o |-> $past(cmd_i.valid && cmd_i.op == ptwl_pkg::CMD_READ)
    && rd_data_o == ($past(cmd_i.addr) == ptwl_pkg::ADDR_TERM_CTRL ? terminal_control_zero_o : wiper_reg_o))
    else $error("read answer wrong");
  chk_err_cause: assert property ($rose(command_error_o) |-> $past(bad))
    else $error("error without illegal command");
  chk_err_frozen: assert property (command_error_o |=> $stable(wiper_reg_o)
    && $stable(terminal_control_zero_o))
    else $error("memory changed in error");
  chk_err_sticky: assert property (err_held |=> command_error_o)
    else $error("error dropped while selected");
  chk_static_drop: assert property (!cs_n_i [*6] |-> !static_mode_o)
    else $error("static mode while selected");
endmodule : ptwl_top_props

bind ptwl_top ptwl_top_props u_ptwl_top_props
(
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
  .terminal_disconnect_pin_n_i(terminal_disconnect_pin_n_i), .wiper_latch_n_i(wiper_latch_n_i),
  .cmd_i(cmd_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .command_error_o(command_error_o),
  .term_o(term_o), .wiper_pos_o(wiper_pos_o), .wiper_reg_o(wiper_reg_o),
  .terminal_control_zero_o(terminal_control_zero_o), .static_mode_o(static_mode_o)
);
`default_nettype wire

// File: test/ptwl_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial host model on the command side
// ----------------------------------------
module ptwl_host
(
  // Clock
  input wire logic ref_clk_i,
  // Select, serial clock and decoded commands
  output logic cs_n_o,
  output logic sclk_o,
  output ptwl_pkg::ptwl_cmd_t cmd_o
);
  // Idle: deselected, clock parked low
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    cmd_o = '0;
  end

  // Select or deselect, then let the pin filter settle
  task automatic sel(input logic on);
    @(posedge ref_clk_i);
    #1;
    cs_n_o = ~on;
    repeat (8) @(posedge ref_clk_i);
    #1;
  endtask : sel

  // Serial clock pulse with select high; four cycles so the pin filter passes it
  task automatic burst;
    @(posedge ref_clk_i);
    #1;
    sclk_o = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    sclk_o = 1'b0;
  endtask : burst

  // One command for one edge; released fields are scrambled
  task automatic send(input logic [1:0] op, input logic [3:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    #1;
    cmd_o = '{1'b1, ptwl_pkg::ptwl_op_t'(op), addr, data};
    sclk_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    cmd_o = '{1'b0, ptwl_pkg::ptwl_op_t'(~op), ~addr, ~data};
    sclk_o = 1'b0;
  endtask : send
endmodule : ptwl_host
`default_nettype wire

// File: test/tb_ptwl_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Testbench of terminal and latch control
// ----------------------------------------
module tb_ptwl_top;
  // Clock, reset and pins; latch tied low unless a test syncs
  logic clk = 1'b0, rst_n = 1'b0, disconnect_n = 1'b1, latch_n = 1'b0;
  logic cs_n, sclk, rd_valid, err, stat;
  logic [7:0] rd_data, pos, wreg, tcz, wreg7;
  ptwl_pkg::ptwl_cmd_t cmd;
  ptwl_pkg::ptwl_term_t term;
  int fail_count = 0, total_checks = 0;
  // Stimulus tables
  logic [1:0] ops [6] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h2};
  logic [7:0] din [6] = '{8'hFE, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] wexp [6] = '{8'hFE, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00};
  logic [7:0] w7exp [6] = '{8'h7E, 8'h7F, 8'h7F, 8'h01, 8'h00, 8'h00};
  logic [3:0] tc [3] = '{4'h5, 4'hD, 4'hA};
  logic [3:0] te [3] = '{4'h1, 4'hA, 4'h4};
  logic [1:0] bop [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [3:0] badr [4] = '{4'h1, 4'h4, 4'h4, 4'hF};

  always #5 clk = ~clk;

  ptwl_top u_ptwl_top
  (
    .ref_clk_i(clk), .resetn_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
    .terminal_disconnect_pin_n_i(disconnect_n), .wiper_latch_n_i(latch_n), .cmd_i(cmd),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .command_error_o(err), .term_o(term),
    .wiper_pos_o(pos), .wiper_reg_o(wreg), .terminal_control_zero_o(tcz), .static_mode_o(stat)
  );

  // Seven-bit variant on the same inputs; only its wiper register is compared
  ptwl_top #(.RES_7BIT(1'b1)) u_ptwl_top_7b
  (
    .ref_clk_i(clk), .resetn_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
    .terminal_disconnect_pin_n_i(disconnect_n), .wiper_latch_n_i(latch_n), .cmd_i(cmd),
    .rd_data_o(), .rd_valid_o(), .command_error_o(), .term_o(),
    .wiper_pos_o(), .wiper_reg_o(wreg7), .terminal_control_zero_o(), .static_mode_o()
  );

  ptwl_host u_ptwl_host (.ref_clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .cmd_o(cmd));

  // Compare and count
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Land just after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Read one location and compare the answer
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    u_ptwl_host.send(2'h3, a, 8'h00);
    chk_byte("rd_valid", 8'h01, {7'h00, rd_valid});
    chk_byte("rd_data", exp, rd_data);
  endtask : rd

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    cyc(10);
    rst_n = 1'b1;
    cyc(12);
    chk_byte("wiper_reg", 8'h7F, wreg);
    chk_byte("wiper_reg_7b", 8'h3F, wreg7);
    chk_byte("wiper_pos", 8'h7F, pos);
    chk_byte("term_ctrl", 8'hFF, tcz);
    chk_byte("term", 8'h0E, {4'h0, term});
    chk_byte("static", 8'h01, {7'h00, stat});
    // A serial clock edge with select high leaves static mode until quiet again
    u_ptwl_host.burst();
    cyc(2);
    chk_byte("static", 8'h00, {7'h00, stat});
    cyc(14);
    chk_byte("static", 8'h01, {7'h00, stat});
    u_ptwl_host.sel(1'b1);
    chk_byte("static", 8'h00, {7'h00, stat});
    rd(4'h0, 8'h7F);
    rd(4'h4, 8'hFF);
    // Write, increment, decrement with saturation at both ends
    for (int i = 0; i < 6; i++)
    begin
      u_ptwl_host.send(ops[i], 4'h0, din[i]);
      cyc(2);
      chk_byte("wiper_reg", wexp[i], wreg);
      chk_byte("wiper_reg_7b", w7exp[i], wreg7);
      chk_byte("wiper_pos", wexp[i], pos);
    end
    // Latch high: register moves, wiper holds
    latch_n = 1'b1;
    cyc(8);
    u_ptwl_host.send(2'h0, 4'h0, 8'h3C);
    cyc(4);
    chk_byte("wiper_reg", 8'h3C, wreg);
    chk_byte("wiper_reg_7b", 8'h3C, wreg7);
    chk_byte("wiper_pos", 8'h00, pos);
    latch_n = 1'b0;
    cyc(8);
    chk_byte("wiper_pos", 8'h3C, pos);
    // Soft shutdown, then A and B without W, then W alone
    for (int i = 0; i < 3; i++)
    begin
      u_ptwl_host.send(2'h0, 4'h4, {4'h0, tc[i]});
      cyc(2);
      chk_byte("term_ctrl", {4'hF, tc[i]}, tcz);
      chk_byte("term", {4'h0, te[i]}, {4'h0, term});
      chk_byte("wiper_reg", 8'h3C, wreg);
    end
    // Hardware pin overrides and keeps the bits
    disconnect_n = 1'b0;
    cyc(8);
    chk_byte("term", 8'h01, {4'h0, term});
    u_ptwl_host.send(2'h0, 4'h4, 8'h0F);
    cyc(2);
    chk_byte("term", 8'h01, {4'h0, term});
    chk_byte("term_ctrl", 8'hFF, tcz);
    chk_byte("wiper_reg", 8'h3C, wreg);
    disconnect_n = 1'b1;
    cyc(8);
    chk_byte("term", 8'h0E, {4'h0, term});
    chk_byte("wiper_pos", 8'h3C, pos);
    // Illegal commands, sticky error, recovery by reselect
    for (int i = 0; i < 4; i++)
    begin
      u_ptwl_host.send(bop[i], badr[i], 8'h11);
      chk_byte("error", 8'h01, {7'h00, err});
      chk_byte("rd_valid", 8'h00, {7'h00, rd_valid});
      u_ptwl_host.send(2'h0, 4'h0, 8'h55);
      chk_byte("error", 8'h01, {7'h00, err});
      chk_byte("wiper_reg", 8'h3C, wreg);
      u_ptwl_host.sel(1'b0);
      chk_byte("error", 8'h00, {7'h00, err});
      u_ptwl_host.sel(1'b1);
    end
    u_ptwl_host.send(2'h0, 4'h0, 8'h55);
    chk_byte("wiper_reg", 8'h55, wreg);
    chk_byte("wiper_reg_7b", 8'h55, wreg7);
    // Brown-out in mid-run: both variants return to their power-on codes
    u_ptwl_host.send(2'h0, 4'h4, 8'h00);
    cyc(2);
    chk_byte("term", 8'h01, {4'h0, term});
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(12);
    chk_byte("wiper_reg", 8'h7F, wreg);
    chk_byte("wiper_reg_7b", 8'h3F, wreg7);
    chk_byte("term_ctrl", 8'hFF, tcz);
    chk_byte("term", 8'h0E, {4'h0, term});
    tally_and_finish();
  end
endmodule : tb_ptwl_top
`default_nettype wire
